// *** hdl/ccdr_defines.vh ***
// Constants for the full frame sensor readout timing generator.
// Assumes a single 20 MHz clock; included by the controller only.
`ifndef CCDR_DEFINES_VH
`define CCDR_DEFINES_VH

`define CCDR_CLK_MHZ        20
`define CCDR_TOTAL_PIX      3103
`define CCDR_TOTAL_LINES    3086
`define CCDR_DUMMY_LEAD     14
`define CCDR_DUMMY_TRAIL    3
`define CCDR_DARK_PIX       20
`define CCDR_DARK_LINES_TOP 20
`define CCDR_DARK_LINES_BOT 9
`define CCDR_EFF_SIZE       3085
`define CCDR_ACT_SIZE       3056
// Active window offset into the lit area; centres it across the columns
`define CCDR_ACT_PIX_OFS    5
`define CCDR_ACT_LINE_OFS   0
// Vertical pulse width in microseconds, cycles derived from it
`define CCDR_VPULSE_US      20
`define CCDR_VPULSE_CYC     (`CCDR_VPULSE_US * `CCDR_CLK_MHZ)
// Clock cycles per horizontal pixel phase (2 MHz pixel rate at 20 MHz)
`define CCDR_HDIV           5
`define CCDR_EXPO_DEFAULT   20000

`endif

// *** hdl/ccdr_ctrl.v ***
// Timing generator driving a full frame sensor's vertical, horizontal
// and clear-gate clocks, plus pixel classification of sampled codes.
// Assumes an external converter presents adc_data on each sample strobe.
`timescale 1ns/1ns
`include "ccdr_defines.vh"

module ccdr_ctrl #(
    parameter DATA_W     = 12,
    parameter TOTAL_PIX  = `CCDR_TOTAL_PIX,
    parameter TOTAL_LINE = `CCDR_TOTAL_LINES,
    parameter VPULSE_CYC = `CCDR_VPULSE_CYC,
    parameter EXPO_CYC   = `CCDR_EXPO_DEFAULT
) (
    input  wire              clk,
    input  wire              reset_n,
    input  wire              frame_start,
    input  wire [DATA_W-1:0] adc_data,
    input  wire              out_ready,
    output reg               vertical_phase_a,
    output reg               vertical_phase_b,
    output reg               horizontal_phase_a,
    output wire              horizontal_phase_b,
    output reg               sense_node_clear_gate,
    output reg               adc_sample,
    output reg               busy,
    output wire              out_valid,
    output wire [DATA_W-1:0] out_data,
    output wire              out_dark,
    output wire              out_active,
    output wire              out_effective,
    output wire              out_line_end,
    output wire              out_frame_end,
    output wire              overflow
);

    // Sequencer state codes
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_EXPO = 3'd1;
    localparam [2:0] ST_VA   = 3'd2;
    localparam [2:0] ST_VB   = 3'd3;
    localparam [2:0] ST_VEND = 3'd4;
    localparam [2:0] ST_HSH  = 3'd5;
    localparam [3:0] HDIV    = `CCDR_HDIV;
    localparam       BW      = DATA_W + 5;

    reg  [2:0]  state_q;
    reg  [31:0] tmr_q;
    reg  [12:0] pix_q;
    reg  [12:0] line_q;
    reg  [3:0]  ph_q;
    reg         ovf_q;

    // Classification of the pixel just sampled
    wire pix_dummy = (pix_q < `CCDR_DUMMY_LEAD) ||
                     (pix_q >= TOTAL_PIX - `CCDR_DUMMY_TRAIL);
    wire pix_dkcol = !pix_dummy &&
                     (pix_q < `CCDR_DUMMY_LEAD + `CCDR_DARK_PIX);
    wire ln_dark   = (line_q < `CCDR_DARK_LINES_TOP) ||
                     (line_q >= TOTAL_LINE - `CCDR_DARK_LINES_BOT);
    // Window corners: both windows stay inside the read frame so they keep
    // their full size; a window running past the frame would silently shrink
    localparam EFF_PX0 = `CCDR_DUMMY_LEAD;
    localparam ACT_PX0 = `CCDR_DUMMY_LEAD + `CCDR_DARK_PIX + `CCDR_ACT_PIX_OFS;
    localparam ACT_LN0 = `CCDR_DARK_LINES_TOP + `CCDR_ACT_LINE_OFS;
    // Effective area: first pixel after the leading dummies, top line on
    wire pix_eff   = (pix_q >= EFF_PX0) && (pix_q < EFF_PX0 + `CCDR_EFF_SIZE) &&
                     (line_q < `CCDR_EFF_SIZE);
    // Active area: lit pixels only, clear of dark lines, columns and dummies
    wire pix_act   = (pix_q >= ACT_PX0) && (pix_q < ACT_PX0 + `CCDR_ACT_SIZE) &&
                     (line_q >= ACT_LN0) && (line_q < ACT_LN0 + `CCDR_ACT_SIZE);
    wire last_pix  = pix_q == TOTAL_PIX - 1;
    wire last_line = line_q == TOTAL_LINE - 1;

    // Code inverted so that a larger word means more light
    wire [BW-1:0] in_word = {~adc_data,
                             !pix_dummy && (pix_dkcol || ln_dark),
                             pix_act, pix_eff, last_pix, last_pix && last_line};
    wire in_ready;

    // Horizontal b is the complement of a by construction
    // One output per clock name; the board fans it to every pin of that
    // name, so all copies of a clock share one edge timing
    assign horizontal_phase_b = ~horizontal_phase_a;
    assign overflow           = ovf_q;

    // Main sequencer: exposure, vertical transfer, horizontal shift
    always @(posedge clk) begin
        if (!reset_n) begin
            state_q               <= ST_IDLE;
            tmr_q                 <= 32'h0;
            pix_q                 <= 13'h0;
            line_q                <= 13'h0;
            ph_q                  <= 4'h0;
            vertical_phase_a      <= 1'b0;
            vertical_phase_b      <= 1'b0;
            horizontal_phase_a    <= 1'b1;
            sense_node_clear_gate <= 1'b0;
            adc_sample            <= 1'b0;
            busy                  <= 1'b0;
            ovf_q                 <= 1'b0;
        end else begin
            adc_sample            <= 1'b0;
            sense_node_clear_gate <= 1'b0;
            // The sensor cannot be paused mid-line, so a full buffer
            // has to drop the sample and flag it
            if (adc_sample && !in_ready)
                ovf_q <= 1'b1;     // Sticky until reset; word dropped
            case (state_q)
            ST_IDLE: begin
                // Requests only looked at here; a restart while busy is ignored
                vertical_phase_a <= 1'b0;
                vertical_phase_b <= 1'b0;
                if (frame_start) begin
                    state_q <= ST_EXPO;
                    tmr_q   <= 32'h0;
                    line_q  <= 13'h0;
                    busy    <= 1'b1;
                end
            end
            ST_EXPO: begin
                // Vertical clocks held low while charge integrates
                vertical_phase_a <= 1'b0;
                vertical_phase_b <= 1'b0;
                if (tmr_q >= EXPO_CYC - 1) begin
                    state_q <= ST_VA;
                    tmr_q   <= 32'h0;
                end else
                    tmr_q <= tmr_q + 32'h1;
            end
            ST_VA: begin
                // Horizontal a kept high across the whole line transfer
                horizontal_phase_a <= 1'b1;
                vertical_phase_a   <= 1'b1;
                if (tmr_q >= VPULSE_CYC - 1) begin
                    state_q          <= ST_VB;
                    tmr_q            <= 32'h0;
                    vertical_phase_a <= 1'b0;
                    vertical_phase_b <= 1'b1;
                end else
                    tmr_q <= tmr_q + 32'h1;
            end
            ST_VB: begin
                // Phase b falls at the end; the line drops into the register
                if (tmr_q >= VPULSE_CYC - 1) begin
                    state_q          <= ST_VEND;
                    tmr_q            <= 32'h0;
                    vertical_phase_b <= 1'b0;
                end else
                    tmr_q <= tmr_q + 32'h1;
            end
            ST_VEND: begin
                // Settle one pulse width before shifting
                if (tmr_q >= VPULSE_CYC - 1) begin
                    state_q <= ST_HSH;
                    tmr_q   <= 32'h0;
                    pix_q   <= 13'h0;
                    ph_q    <= 4'h0;
                end else
                    tmr_q <= tmr_q + 32'h1;
            end
            ST_HSH: begin
                // One pixel per two phases; sample then clear the node
                if (ph_q == HDIV - 1) begin
                    ph_q               <= 4'h0;
                    horizontal_phase_a <= ~horizontal_phase_a;
                    if (horizontal_phase_a)
                        adc_sample <= 1'b1;
                    else if (last_pix) begin
                        state_q            <= last_line ? ST_IDLE : ST_VA;
                        busy               <= !last_line;
                        line_q             <= last_line ? 13'h0 : line_q + 13'h1;
                        horizontal_phase_a <= 1'b1;
                    end else
                        pix_q <= pix_q + 13'h1;
                end else
                    ph_q <= ph_q + 4'h1;
                if (adc_sample)
                    sense_node_clear_gate <= 1'b1;
            end
            default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Two-entry buffer; a stall loses no word until both entries are full, then a new word is dropped
    reg  [BW-1:0] buf_q [0:1];
    reg           wr_q;
    reg           rd_q;
    reg  [1:0]    cnt_q;
    wire          push = adc_sample && in_ready;
    wire          pop  = out_valid && out_ready;
    assign in_ready  = cnt_q != 2'd2;
    assign out_valid = cnt_q != 2'd0;
    wire [BW-1:0] head = buf_q[rd_q];

    always @(posedge clk) begin
        if (!reset_n) begin
            wr_q     <= 1'b0;
            rd_q     <= 1'b0;
            cnt_q    <= 2'd0;
            buf_q[0] <= {BW{1'b0}};
            buf_q[1] <= {BW{1'b0}};
        end else begin
            if (push) begin
                buf_q[wr_q] <= in_word;
                wr_q        <= ~wr_q;
            end
            if (pop)
                rd_q <= ~rd_q;
            // Push and pop in one cycle leave the count as it is
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // Flags travel beside the code so each word describes itself
    assign out_data      = head[BW-1:5];
    assign out_dark      = head[4];
    assign out_active    = head[3];
    assign out_effective = head[2];
    assign out_line_end  = head[1];
    assign out_frame_end = head[0];

endmodule

// *** dv/ccdr_ctrl_chk.sv ***
// Port checker for the readout timing controller.
// Bound to every ccdr_ctrl instance; sees its ports only.
`timescale 1ns/1ns
module ccdr_ctrl_chk #(
    parameter DATA_W = 12
) (
    input logic              clk,
    input logic              reset_n,
    input logic              out_ready,
    input logic              vertical_phase_a,
    input logic              vertical_phase_b,
    input logic              horizontal_phase_a,
    input logic              horizontal_phase_b,
    input logic              sense_node_clear_gate,
    input logic              adc_sample,
    input logic              busy,
    input logic              out_valid,
    input logic [DATA_W-1:0] out_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Vertical clocks parked low while idle and for the first 8 cycles of exposure
    a_idle_vert_low:
        assert property (!busy |-> !vertical_phase_a && !vertical_phase_b) else $error("vert high idle");
    a_expose_vert_low:
        assert property ($rose(busy) |-> (!vertical_phase_a && !vertical_phase_b)[*8])
        else $error("vert moved in exposure");
    a_load_ha_high:
        assert property ($fell(vertical_phase_b) |-> horizontal_phase_a) else $error("load, ha low");
    // Phase b mirrors a through the whole low half of a pixel
    a_h_low_phase:
        assert property ($fell(horizontal_phase_a) |-> (horizontal_phase_b && !horizontal_phase_a)[*5])
        else $error("horizontal phase bad");
    a_sample_on_fall:
        assert property ($fell(horizontal_phase_a) |-> adc_sample) else $error("no sample");
    a_clear_after:
        assert property (adc_sample |=> sense_node_clear_gate ##1 !sense_node_clear_gate)
        else $error("clear gate pulse bad");
    a_vert_h_static:
        assert property ((vertical_phase_a || vertical_phase_b) |-> horizontal_phase_a && !adc_sample)
        else $error("shift during transfer");
    // A stalled word must not change under the receiver
    a_hold_stall:
        assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("stalled word changed");
    c_line_load: cover property ($fell(vertical_phase_b));
    c_stall: cover property (out_valid && !out_ready);
    c_frame_done: cover property ($fell(busy));
endmodule
bind ccdr_ctrl ccdr_ctrl_chk #(.DATA_W(DATA_W)) chk_u (.*);

// *** dv/ccdr_sensor_model.sv ***
// Behavioural sensor plus converter: codes carry line and pixel index.
// Assumes the controller idles with horizontal phase a high.
`timescale 1ns/1ns
module ccdr_sensor_model (
    input  logic        vertical_phase_b,
    input  logic        horizontal_phase_a,
    output logic [11:0] adc_data
);
    logic [5:0] line_q = 6'h3f;
    logic [5:0] pix_q = 6'h3f;
    logic       vb_seen = 1'b0;
    // Ignore the power-up edge from unknown, it moves no charge
    always @(posedge vertical_phase_b) vb_seen = 1'b1;
    // Line enters the horizontal register only while phase a is high
    always @(negedge vertical_phase_b) begin
        if (vb_seen && horizontal_phase_a === 1'b1) begin
            line_q <= line_q + 6'h01;
            pix_q <= 6'h3f;
        end
    end
    // Each fall of phase a puts the next pixel on the sense node
    always @(negedge horizontal_phase_a) pix_q <= pix_q + 6'h01;
    assign adc_data = ~{line_q, pix_q};
endmodule

// *** dv/ccdr_ctrl_test.sv ***
// Self-checking bench for the readout timing controller.
// Reduced frame geometry; sensor model drives the converter input.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module ccdr_ctrl_test;
    localparam TP = 40, TL = 32;
    logic        clk, reset_n, frame_start, out_ready;
    logic [11:0] adc_data, out_data;
    logic        vertical_phase_a, vertical_phase_b, horizontal_phase_a, horizontal_phase_b;
    logic        sense_node_clear_gate, smp, busy, out_valid, dark, lend, fend, ovf, act, eff;
    int          miscompares = 0, checked = 0, lbase = 0;
    ccdr_ctrl #(.TOTAL_PIX(TP), .TOTAL_LINE(TL), .VPULSE_CYC(4), .EXPO_CYC(10)) dut_u (
        .clk, .reset_n, .frame_start, .adc_data, .out_ready, .vertical_phase_a,
        .vertical_phase_b, .horizontal_phase_a, .horizontal_phase_b, .sense_node_clear_gate,
        .adc_sample(smp), .busy, .out_valid, .out_data, .out_dark(dark), .out_active(act),
        .out_effective(eff), .out_line_end(lend), .out_frame_end(fend), .overflow(ovf));
    ccdr_sensor_model model_u (.vertical_phase_b, .horizontal_phase_a, .adc_data);
    // Clock, 50 ns period
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    task complete_run;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One frame; with stall the receiver drops ready and a restart is tried mid-frame
    task automatic t_frame(input bit stall);
        int n, c, p, l;
        bit dk;
        n = 0;
        c = 0;
        repeat (20) @(posedge clk);
        #1 frame_start = 1;
        @(posedge clk) #1 frame_start = 0;
        while (n < TP * TL && c < 20000) begin
            @(negedge clk);
            c++;
            p = n % TP;
            l = n / TP;
            // Dark: shielded columns or top and bottom lines, never a dummy
            dk = p > 13 && p < TP - 3 && (p < 34 || l < 20 || l >= TL - 9);
            if (out_valid === 1'b1 && out_ready === 1'b1) begin
                n++;
                `CHK("pixel", {6'(lbase + l), 6'(p)}, out_data)
                `CHK("dark", dk, dark)
                `CHK("effective", p >= 14 && l < 3085, eff)
                `CHK("active", p >= 39 && l >= 20, act)
                `CHK("ends", {p == TP - 1, n == TP * TL}, {lend, fend})
            end
            @(posedge clk) #1;
            out_ready = !stall || c % 16 > 5;
            frame_start = stall && c == 600;
        end
        lbase += TL;
        `CHK("words", TP * TL, n)
        `CHK("overflow", 1'b0, ovf)
    endtask
    // Receiver never ready: third word is lost, then reset aborts the frame
    task automatic t_overflow;
        int c;
        repeat (20) @(posedge clk);
        #1 out_ready = 0;
        frame_start = 1;
        @(posedge clk) #1 frame_start = 0;
        for (c = 0; c < 2000 && ovf !== 1'b1; c++) @(posedge clk) #1;
        `CHK("overflow", 1'b1, ovf)
        `CHK("held", {1'b1, 6'(lbase), 6'h00}, {out_valid, out_data})
        reset_n = 0;
        @(posedge clk) #1 reset_n = 1;
        `CHK("abort", 4'h0, {busy, out_valid, ovf, vertical_phase_b})
    endtask
    initial begin
        reset_n = 0;
        frame_start = 0;
        out_ready = 1;
        repeat (3) @(posedge clk);
        #1 `CHK("reset", 9'h040, {vertical_phase_a, vertical_phase_b, horizontal_phase_a,
            horizontal_phase_b, sense_node_clear_gate, smp, busy, out_valid, ovf})
        reset_n = 1;
        t_frame(0);
        t_frame(1);
        t_overflow;
        complete_run;
    end
    // Two frames and the short overflow run need about 26500 cycles
    initial begin
        #4000000;
        miscompares++;
        complete_run;
    end
endmodule
